// File: design/core_regs_cfg.svh
// Register offsets, bit positions and reset values of the core register group
`ifndef CORE_REGS_CFG_SVH
`define CORE_REGS_CFG_SVH
`define OFS_STATUS   8'h03
`define OFS_INTCTL   8'h0b
`define OFS_OPTION   8'h81
`define OFS_PIEMASK  8'h8c
`define OFS_PINCHG   8'h96
`define OFS_STATUS_B 8'h83
`define OFS_INTCTL_B 8'h8b
`define RST_OPTION   8'hff
`define RST_INTCTL   8'h00
`define RST_PIEMASK  8'h00
`define RST_PINCHG   8'h00
`define PIEMASK_IMPL 8'hc9
`define ST_BANK      5
`define ST_TO        4
`define ST_PD        3
`define ST_Z         2
`define ST_DC        1
`define ST_C         0
`define IC_GIE       7
`define IC_PERIPHERAL_IRQ_GATE      6
`define IC_TIMER0_IRQ_ENABLE      5
`define IC_EXT_IRQ_ENABLE      4
`define IC_PORT_CHANGE_IRQ_ENABLE      3
`define IC_TIMER0_OVERFLOW_FLAG      2
`define IC_EXT_IRQ_FLAG      1
`define IC_PORT_CHANGE_FLAG      0
`define OP_PUDIS     7
`define OP_EDGE      6
`define OP_T0SRC     5
`define OP_T0EDGE    4
`define OP_PSA       3
`endif

// File: design/core_regs_pkg.sv
// Types shared by the core register group
package core_regs_pkg;
	// ALU result report from the core datapath
	typedef struct packed {
		logic       valid;     // One-cycle strobe: an instruction finished
		logic       upd_z;     // Instruction affects the zero flag
		logic       upd_arith; // Add/subtract: half-carry and carry affected
		logic       upd_rot;   // Rotate through carry
		logic [7:0] result;    // Operation result
		logic       dc;        // Carry out of bit 3
		logic       c;         // Carry out of bit 7
		logic       rot_out;   // Bit shifted out by a rotate
	} alu_report_t;
	// Register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// File: design/core_status_option_irq_regs.sv
// Core status, option and interrupt control registers of a small 8-bit controller
//
// Behaviour
// (R1) ALU flag writes to status yield to result
// (R2) Software cannot write timeout or powerdown flags
// (R3) Status bit 5 selects direct bank
// (R4) Timeout flag set by power-up/clear/sleep, cleared by timeout
// (R5) Powerdown flag set by power-up/clear, cleared by sleep
// (R6) Zero flag follows result equal zero
// (R7) Half-carry captures bit-3 carry out
// (R8) Carry captures bit-7 carry out
// (R9) Rotates load carry with shifted-out bit
// (R10) Option bit 7 disables all pull-ups
// (R11) Option bit 6 picks external interrupt edge
// (R12) Option bit 5 picks timer0 clock source
// (R13) Option bit 4 picks timer0 pin edge
// (R14) Option bit 3 gives prescaler to watchdog
// (R15) Rate field sets prescaler division
// (R16) Flags set regardless of enables
// (R17) Global enable gates all interrupts
// (R18) Peripheral gate enables peripheral interrupts
// (R19) Port-change needs per-pin enable too
// (R20) Timer0 overflow flag sticky until cleared
// (R21) Pin edge and port change set flags
// (R22) Peripheral mask layout, unused bits zero
// (R23) Request equals gated OR of enabled flags
//
// Strobed register access is this design's own decision.
`include "core_regs_cfg.svh"

module core_status_option_irq_regs #(
	parameter int PORT_W = 6 // Port A width watched for change
) (
	input  wire logic                       sys_clk_in,
	input  wire logic                       rst_b_in,          // Synchronous, active low
	input  wire logic                       por_in,            // Power-up reset (same clock)
	input  wire core_regs_pkg::reg_req_t    req_in,            // Register bus request
	input  wire core_regs_pkg::alu_report_t alu_in,            // ALU report
	input  wire logic                       wdt_clear_in,      // Watchdog-clear instruction
	input  wire logic                       sleep_in,          // Sleep instruction
	input  wire logic                       wdt_timeout_in,    // Watchdog time-out event
	input  wire logic                       timer0_rollover_in,// Timer0 overflow pulse
	input  wire logic                       ext_irq_pin_in,    // External interrupt pin
	input  wire logic                       timer0_clock_pin_in,// External timer clock pin
	input  wire logic [PORT_W-1:0]          porta_pins_in,     // Port A pins
	input  wire logic [PORT_W-1:0]          pullup_pin_en_in,  // Per-pin pull-up settings
	input  wire logic [7:0]                 periph_flags_in,   // Peripheral flag register
	output logic [7:0]                      rdata_out,
	output logic                            bank_select_out,
	output logic [PORT_W-1:0]               pullup_en_out,
	output logic                            timer0_tick_out,   // Prescaled timer0 count pulse
	output logic                            wdt_tick_out,      // Prescaled watchdog tick
	output logic                            irq_out
);
	// Core register state
	logic [7:0]        status_q;
	logic [7:0]        option_q;
	logic [7:0]        intctl_q;
	logic [7:0]        piemask_q;
	logic [PORT_W-1:0] pinchg_q;   // Per-pin change enables
	logic [7:0]        status_d;
	logic [7:0]        intctl_d;

	// Three-stage synchronisers for pins; stage 1 feeds only stage 2
	logic [PORT_W+1:0] sync1_q;
	logic [PORT_W+1:0] sync2_q;
	logic [PORT_W+1:0] sync3_q;
	logic [PORT_W+1:0] stable_q;   // Last agreed value
	logic [PORT_W+1:0] pin_raw;
	assign pin_raw = {timer0_clock_pin_in, ext_irq_pin_in, porta_pins_in};

	// Agreement of stages 2 and 3 declares a new level
	wire [PORT_W+1:0] agree   = ~(sync2_q ^ sync3_q);
	wire [PORT_W+1:0] changed = agree & (sync3_q ^ stable_q);
	wire [PORT_W+1:0] new_lvl = (sync3_q & agree) | (stable_q & ~agree);

	// Pin synchroniser and level tracker
	always_ff @(posedge sys_clk_in) begin
		sync1_q  <= pin_raw;
		sync2_q  <= sync1_q;
		sync3_q  <= sync2_q;
		stable_q <= new_lvl;
	end

	// Events from the pins
	wire ext_rise  = changed[PORT_W] & sync3_q[PORT_W];
	wire ext_fall  = changed[PORT_W] & ~sync3_q[PORT_W];
	wire ext_event = option_q[`OP_EDGE] ? ext_rise : ext_fall; // [R11]
	wire t0p_rise  = changed[PORT_W+1] & sync3_q[PORT_W+1];
	wire t0p_fall  = changed[PORT_W+1] & ~sync3_q[PORT_W+1];
	wire t0p_event = option_q[`OP_T0EDGE] ? t0p_fall : t0p_rise; // [R13]
	wire port_event = |changed[PORT_W-1:0]; // [R21]

	// Instruction-cycle clock: one enable every fourth system clock
	logic [1:0] icyc_q;
	wire        icyc_tick = (icyc_q == 2'h3);
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			icyc_q <= 2'h0;
		end else begin
			icyc_q <= icyc_q + 2'h1;
		end
	end

	// Timer0 source and shared prescaler
	wire t0_src  = option_q[`OP_T0SRC] ? t0p_event : icyc_tick; // [R12]
	wire to_wdt  = option_q[`OP_PSA]; // [R14]
	wire pre_in  = to_wdt ? icyc_tick : t0_src;
	logic [7:0] pre_q;
	wire [7:0] pre_nx = pre_q + 8'h01;
	// Division: timer0 2^(code+1), watchdog 2^code
	wire [3:0] shift = to_wdt ? {1'b0, option_q[2:0]} : ({1'b0, option_q[2:0]} + 4'h1);
	wire [8:0] span_mask = (9'h001 << shift) - 9'h001;
	wire pre_wrap = pre_in & ((pre_nx & span_mask[7:0]) == 8'h00); // [R15]
	wire pre_out  = (shift == 4'h0) ? pre_in : pre_wrap;

	// Prescaler counter; a write to option restarts it
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || (req_in.wr && req_in.addr == `OFS_OPTION)) begin
			pre_q <= 8'h00;
		end else if (pre_in) begin
			pre_q <= pre_nx;
		end
	end

	// Tick outputs: unprescaled timer0 while watchdog owns prescaler
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			timer0_tick_out <= 1'b0;
			wdt_tick_out    <= 1'b0;
		end else begin
			timer0_tick_out <= to_wdt ? t0_src : pre_out; // [R14]
			wdt_tick_out    <= to_wdt ? pre_out : icyc_tick;
		end
	end

	// Address decode; status and interrupt control mirror into bank 1
	wire sel_status = (req_in.addr == `OFS_STATUS) || (req_in.addr == `OFS_STATUS_B);
	wire sel_intctl = (req_in.addr == `OFS_INTCTL) || (req_in.addr == `OFS_INTCTL_B);
	wire sel_option = (req_in.addr == `OFS_OPTION);
	wire sel_pie    = (req_in.addr == `OFS_PIEMASK);
	wire sel_pinchg = (req_in.addr == `OFS_PINCHG);
	wire wr_status  = req_in.wr & sel_status;
	wire wr_intctl  = req_in.wr & sel_intctl;

	// Status next value: software first, then hardware overrides
	always_comb begin
		status_d = status_q;
		if (wr_status) begin
			// Reserved bits stay clear; timeout and powerdown not writable
			status_d[`ST_BANK] = req_in.wdata[`ST_BANK]; // [R2]
			status_d[2:0]      = req_in.wdata[2:0];
		end
		if (alu_in.valid && alu_in.upd_z) begin
			status_d[`ST_Z] = (alu_in.result == 8'h00); // [R1] [R6]
		end
		if (alu_in.valid && alu_in.upd_arith) begin
			status_d[`ST_DC] = alu_in.dc; // [R1] [R7]
			status_d[`ST_C]  = alu_in.c;  // [R8]
		end
		if (alu_in.valid && alu_in.upd_rot) begin
			status_d[`ST_C] = alu_in.rot_out; // [R9]
		end
		// Reset-cause flags move only on hardware events
		if (wdt_clear_in) begin
			status_d[`ST_TO] = 1'b1; // [R4]
			status_d[`ST_PD] = 1'b1; // [R5]
		end else if (sleep_in) begin
			status_d[`ST_TO] = 1'b1; // [R4]
			status_d[`ST_PD] = 1'b0; // [R5]
		end
		if (wdt_timeout_in) begin
			status_d[`ST_TO] = 1'b0; // [R4]
		end
	end

	// Interrupt control next value; hardware set wins over software clear
	always_comb begin
		intctl_d = intctl_q;
		if (wr_intctl) begin
			intctl_d = req_in.wdata;
		end
		if (timer0_rollover_in) begin
			intctl_d[`IC_TIMER0_OVERFLOW_FLAG] = 1'b1; // [R16] [R20]
		end
		if (ext_event) begin
			intctl_d[`IC_EXT_IRQ_FLAG] = 1'b1; // [R16] [R21]
		end
		if (|(changed[PORT_W-1:0] & pinchg_q)) begin
			intctl_d[`IC_PORT_CHANGE_FLAG] = 1'b1; // [R19] [R21]
		end
	end

	// Register file; status keeps its timeout/powerdown across non-power resets
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			status_q  <= {3'h0, status_q[`ST_TO], status_q[`ST_PD], status_q[2:0]};
			option_q  <= `RST_OPTION;
			intctl_q  <= `RST_INTCTL;
			piemask_q <= `RST_PIEMASK;
			pinchg_q  <= PORT_W'(`RST_PINCHG);
			if (por_in) begin
				status_q <= 8'h18; // Power-up: timeout and powerdown read 1 [R4] [R5]
			end
		end else begin
			status_q <= status_d;
			intctl_q <= intctl_d;
			if (por_in) begin
				status_q[`ST_TO] <= 1'b1;
				status_q[`ST_PD] <= 1'b1;
			end
			if (req_in.wr && sel_option) begin
				option_q <= req_in.wdata;
			end
			if (req_in.wr && sel_pie) begin
				piemask_q <= req_in.wdata & `PIEMASK_IMPL; // [R22]
			end
			if (req_in.wr && sel_pinchg) begin
				pinchg_q <= req_in.wdata[PORT_W-1:0];
			end
		end
	end

	// Interrupt request terms
	wire core_term = (intctl_q[`IC_TIMER0_IRQ_ENABLE] & intctl_q[`IC_TIMER0_OVERFLOW_FLAG])
		| (intctl_q[`IC_EXT_IRQ_ENABLE] & intctl_q[`IC_EXT_IRQ_FLAG])
		| (intctl_q[`IC_PORT_CHANGE_IRQ_ENABLE] & intctl_q[`IC_PORT_CHANGE_FLAG]); // [R19]
	wire per_term  = intctl_q[`IC_PERIPHERAL_IRQ_GATE] & |(piemask_q & periph_flags_in); // [R18]
	wire irq_d     = intctl_q[`IC_GIE] & (core_term | per_term); // [R17] [R23]

	// Read mux; unmapped addresses read zero
	wire [7:0] rd_mux = sel_status ? status_q
		: sel_intctl ? intctl_q
		: sel_option ? option_q
		: sel_pie    ? piemask_q
		: sel_pinchg ? {{(8-PORT_W){1'b0}}, pinchg_q}
		: 8'h00;

	// Pull-up disable taken from the live option register
	wire option_d_pud = option_q[`OP_PUDIS];

	// Registered outputs
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			rdata_out       <= 8'h00;
			bank_select_out <= 1'b0;
			pullup_en_out   <= '0;
			irq_out         <= 1'b0;
		end else begin
			rdata_out       <= req_in.rd ? rd_mux : 8'h00;
			bank_select_out <= status_d[`ST_BANK]; // [R3]
			pullup_en_out   <= option_d_pud ? '0 : pullup_pin_en_in; // [R10]
			irq_out         <= irq_d;
		end
	end
endmodule

// File: test/core_regs_checker.sv
// Checker of the register group outputs against bus requests and timer ticks
module core_regs_checker #(
	parameter int PORT_W = 6 // Port width, handed on by the bind
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_b_in,
	input  wire core_regs_pkg::reg_req_t req_in,
	input  wire logic [7:0]              rdata_out,
	input  wire logic                    bank_select_out,
	input  wire logic [PORT_W-1:0]       pullup_pin_en_in,
	input  wire logic [PORT_W-1:0]       pullup_en_out,
	input  wire logic                    timer0_tick_out,
	input  wire logic                    irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Decoded writes; status and interrupt control answer in both banks
	wire st_wr = req_in.wr && req_in.addr[6:0] == 7'h03;
	wire op_wr = req_in.wr && req_in.addr == 8'h81;
	wire ic_wr = req_in.wr && req_in.addr[6:0] == 7'h0b;
	property p_pie_rsvd;
		$past(req_in.rd && req_in.addr == 8'h8c) |-> (rdata_out & 8'h36) == 8'h00;
	endproperty
	a_pie_rsvd: assert property (p_pie_rsvd) else $error("spare mask bits read set");
	property p_st_rsvd;
		$past(req_in.rd && req_in.addr[6:0] == 7'h03) |-> rdata_out[7:6] == 2'b00;
	endproperty
	a_st_rsvd: assert property (p_st_rsvd) else $error("reserved status bits set");
	property p_bank1;
		st_wr && req_in.wdata[5] |-> ##[1:2] bank_select_out;
	endproperty
	a_bank1: assert property (p_bank1) else $error("bank select not raised");
	property p_bank0;
		st_wr && !req_in.wdata[5] |-> ##[1:2] !bank_select_out;
	endproperty
	a_bank0: assert property (p_bank0) else $error("bank select not lowered");
	property p_bank_hold;
		!st_wr [*3] |-> $stable(bank_select_out);
	endproperty
	a_bank_hold: assert property (p_bank_hold) else $error("bank moved without write");
	property p_pu_off;
		op_wr && req_in.wdata[7] ##1 !op_wr |=> pullup_en_out == '0;
	endproperty
	a_pu_off: assert property (p_pu_off) else $error("pull-ups left on");
	property p_pu_on;
		op_wr && !req_in.wdata[7] ##1 !op_wr |=> pullup_en_out == $past(pullup_pin_en_in);
	endproperty
	a_pu_on: assert property (p_pu_on) else $error("pull-ups not per pin");
	property p_gie_off;
		ic_wr && !req_in.wdata[7] ##1 !ic_wr [*2] |-> !irq_out;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("request with global off");
	property p_t0_gap;
		timer0_tick_out |=> !timer0_tick_out [*3];
	endproperty
	a_t0_gap: assert property (p_t0_gap) else $error("timer0 ticks too close");
endmodule

bind core_status_option_irq_regs core_regs_checker #(.PORT_W(PORT_W)) u_chk (.sys_clk_in,
	.rst_b_in, .req_in, .rdata_out, .bank_select_out, .pullup_pin_en_in, .pullup_en_out,
	.timer0_tick_out, .irq_out);

// File: test/core_status_option_irq_regs_tb.sv
// Self-checking bench of the core status, option and interrupt registers
module core_status_option_irq_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	core_regs_pkg::reg_req_t    req_in;
	core_regs_pkg::alu_report_t alu_in;
	logic        sys_clk_in, rst_b_in, por_in, wdt_clear_in, sleep_in, wdt_timeout_in;
	logic        timer0_rollover_in, ext_irq_pin_in, timer0_clock_pin_in, irq_out;
	logic        bank_select_out, timer0_tick_out, wdt_tick_out;
	logic [5:0]  porta_pins_in, pullup_pin_en_in, pullup_en_out;
	logic [7:0]  periph_flags_in, rdata_out;
	logic [7:0]  ev_exp [3] = '{8'h10, 8'h00, 8'h18}; // After sleep, time-out, clear
	logic [23:0] irq_tbl [8] = '{24'h120000, 24'h920000, 24'h820000, 24'h800101,
		24'hc00101, 24'hc00001, 24'h400101, 24'ha40000}; // Control, mask, flags
	logic [7:0]  irq_exp = 8'h92; // Expected request, one bit per table row
	int          err_total, n_checks, ticks, wticks;
	core_status_option_irq_regs dut (.sys_clk_in, .rst_b_in, .por_in, .req_in, .alu_in,
		.wdt_clear_in, .sleep_in, .wdt_timeout_in, .timer0_rollover_in, .ext_irq_pin_in,
		.timer0_clock_pin_in, .porta_pins_in, .pullup_pin_en_in, .periph_flags_in,
		.rdata_out, .bank_select_out, .pullup_en_out, .timer0_tick_out, .wdt_tick_out,
		.irq_out);
	// 10 MHz clock
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	// Tick counter; read only between edges to avoid a race
	always @(posedge sys_clk_in) if (timer0_tick_out === 1'b1) ticks++;
	// Watchdog tick counter, same sampling as the timer0 one
	always @(posedge sys_clk_in) if (wdt_tick_out === 1'b1) wticks++;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		req_in <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk_in);
		req_in.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge sys_clk_in);
		req_in <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk_in);
		req_in.rd <= 1'b0;
		#1 chk(rdata_out & m, e);
	endtask
	// ALU report, optionally with a clashing status write of 07h
	task automatic alu(input core_regs_pkg::alu_report_t a, input logic w);
		@(posedge sys_clk_in);
		alu_in <= a;
		req_in <= '{w, 1'b0, 8'h03, 8'h07};
		@(posedge sys_clk_in);
		alu_in.valid <= 1'b0;
		req_in.wr <= 1'b0;
	endtask
	// 0 sleep, 1 time-out, 2 watchdog clear, 3 timer0 roll-over
	task automatic ev(input int k);
		@(posedge sys_clk_in);
		{timer0_rollover_in, wdt_clear_in, wdt_timeout_in, sleep_in} <= 4'h1 << k;
		@(posedge sys_clk_in);
		{timer0_rollover_in, wdt_clear_in, wdt_timeout_in, sleep_in} <= 4'h0;
	endtask
	task automatic rate(input logic [7:0] opt, input int p);
		wr(8'h81, opt);
		cyc(40);
		ticks = 0;
		wticks = 0;
		cyc(4 * p);
		chk(8'(ticks), 8'h04);
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{req_in, alu_in, wdt_clear_in, sleep_in, wdt_timeout_in, timer0_rollover_in} = '0;
		{ext_irq_pin_in, timer0_clock_pin_in, porta_pins_in, periph_flags_in, rst_b_in} = '0;
		por_in = 1'b1;
		pullup_pin_en_in = 6'h2a;
		repeat (12) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		por_in <= 1'b0;
		rd(8'h03, 8'hff, 8'h18);
		rd(8'h81, 8'hff, 8'hff);
		chk({2'b00, pullup_en_out}, 8'h00);
		wr(8'h81, 8'h7f);
		cyc(3);
		chk({2'b00, pullup_en_out}, 8'h2a);
		wr(8'h03, 8'hff);
		rd(8'h03, 8'hff, 8'h3f);
		chk({7'h00, bank_select_out}, 8'h01);
		wr(8'h83, 8'h00);
		rd(8'h83, 8'hff, 8'h18);
		wr(8'h8c, 8'hff);
		rd(8'h8c, 8'hff, 8'hc9);
		$display("test registers done");
		alu('{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0}, 1'b1);
		rd(8'h03, 8'h07, 8'h06);
		alu('{1'b1, 1'b1, 1'b1, 1'b0, 8'h5a, 1'b0, 1'b1, 1'b0}, 1'b0);
		rd(8'h03, 8'h07, 8'h01);
		alu('{1'b1, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0}, 1'b0);
		rd(8'h03, 8'h07, 8'h00);
		for (int k = 0; k < 3; k++) begin
			ev(k);
			rd(8'h03, 8'h18, ev_exp[k]);
		end
		ev(3);
		cyc(20);
		rd(8'h0b, 8'h04, 8'h04);
		wr(8'h0b, 8'h00);
		rd(8'h0b, 8'h04, 8'h00);
		$display("test status events done");
		// Falling edge selected first, then rising
		for (int s = 0; s < 2; s++) begin
			wr(8'h81, s ? 8'h40 : 8'h00);
			wr(8'h0b, 8'h00);
			@(posedge sys_clk_in) ext_irq_pin_in <= 1'b1;
			cyc(8);
			rd(8'h0b, 8'h02, s ? 8'h02 : 8'h00);
			wr(8'h0b, 8'h00);
			@(posedge sys_clk_in) ext_irq_pin_in <= 1'b0;
			cyc(8);
			rd(8'h0b, 8'h02, s ? 8'h00 : 8'h02);
		end
		// Only pin 0 may raise the change request
		wr(8'h96, 8'h01);
		wr(8'h0b, 8'h88);
		@(posedge sys_clk_in) porta_pins_in <= 6'h02;
		cyc(8);
		chk({7'h00, irq_out}, 8'h00);
		@(posedge sys_clk_in) porta_pins_in <= 6'h03;
		cyc(8);
		chk({7'h00, irq_out}, 8'h01);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk_in) periph_flags_in <= irq_tbl[i][7:0];
			wr(8'h8c, irq_tbl[i][15:8]);
			wr(8'h0b, irq_tbl[i][23:16]);
			cyc(3);
			chk({7'h00, irq_out}, {7'h00, irq_exp[i]});
		end
		$display("test interrupts done");
		rate(8'hc0, 8);
		rate(8'hc2, 32);
		rate(8'hc8, 4);
		chk(8'(wticks), 8'h04);
		// Pin source, rising edge counted first, then falling
		for (int s = 0; s < 2; s++) begin
			wr(8'h81, s ? 8'hf8 : 8'he8);
			cyc(2);
			ticks = 0;
			@(posedge sys_clk_in) timer0_clock_pin_in <= 1'b1;
			cyc(12);
			chk(8'(ticks), s ? 8'h00 : 8'h01);
			@(posedge sys_clk_in) timer0_clock_pin_in <= 1'b0;
			cyc(12);
			chk(8'(ticks), 8'h01);
		end
		$display("test timer0 done");
		give_verdict();
	end
	// Hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#3000000;
		err_total++;
		give_verdict();
	end
endmodule
